// *** hdl/pcic_pkg.sv ***
`default_nettype none
package pcic_pkg;
  localparam int NUM_IN = 4;
  localparam int NUM_CNT = 4;
  localparam int NUM_PO = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int LANE_W = 8;
  localparam int CFG_W = 7;
  localparam int EV_W = 8;

  // ==========================================================================
  // Register map.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IN_CFG = 8'h04;
  localparam logic [7:0] OFS_CNT_CFG = 8'h08;
  localparam logic [7:0] OFS_RST_BITS = 8'h0C;
  localparam logic [7:0] OFS_CMP_FLAGS = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_PIN_STATE = 8'h1C;
  localparam logic [3:0] PAGE_RING = 4'h2;
  localparam logic [3:0] PAGE_COUNT = 4'h3;
  localparam logic [3:0] PAGE_LATCH = 4'h4;
  localparam int CTRL_POWER_ON = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_RUN = 0;

  // ==========================================================================
  // Reset values and limits.
  localparam logic [31:0] STAGE_RST = 32'h0000_0000;
  localparam logic [31:0] RING_MAX_RST = 32'h0000_0000;
  localparam logic [31:0] FULL_MAX = 32'hFFFF_FFFF;
  localparam logic [31:0] LIN_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] LIN_MIN = 32'h8000_0000;
  localparam logic [3:0] LATCH_NONE = 4'h0;
  localparam logic [3:0] LATCH_PO0 = 4'h1;
  localparam logic [3:0] LATCH_CNT0 = 4'h5;
  localparam logic [3:0] LATCH_LAST = 4'h8;

  // ==========================================================================
  // Timing of the counter input noise filter.
  localparam int CLK_NS = 8;
  localparam int FILT_60K_NS = 2000;
  localparam int FILT_100K_NS = 1000;
  localparam int FILT_60K_CYC = FILT_60K_NS / CLK_NS;
  localparam int FILT_100K_CYC = FILT_100K_NS / CLK_NS;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {FN_PLAIN = 2'h0, FN_FAST = 2'h1, FN_IRQ = 2'h2} pcic_func_type;
  typedef enum logic [1:0] {FQ_OFF = 2'h0, FQ_60K = 2'h1, FQ_100K = 2'h2} pcic_freq_type;
  typedef enum logic [1:0] {ENC_QUAD = 2'h0, ENC_PDIR = 2'h1, ENC_UPDN = 2'h3,
                            ENC_INC = 2'h2} pcic_enc_type;
  typedef enum logic {ST_STOP = 1'b0, ST_RUN = 1'b1} pcic_run_type;

  typedef struct packed {
    logic [3:0]    latch;
    logic          fall;
    pcic_func_type func;
  } pcic_in_cfg_type;

  typedef struct packed {
    pcic_enc_type  enc;
    logic          cont;
    logic          sw_only;
    logic          ring;
    pcic_freq_type freq;
  } pcic_cnt_cfg_type;

  localparam pcic_in_cfg_type IN_CFG_RST = '{LATCH_NONE, 1'b0, FN_PLAIN};
  localparam pcic_cnt_cfg_type CNT_CFG_RST = '{ENC_QUAD, 1'b0, 1'b0, 1'b0, FQ_OFF};
endpackage
`default_nettype wire

// *** hdl/pcic_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcic_counter #(
  parameter int FILT_W = 8
) (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  var  pcic_pkg::pcic_cnt_cfg_type cfg,
  input  wire logic [31:0]                ring_max,
  input  wire logic                       pin_a,
  input  wire logic                       pin_b,
  input  wire logic                       pin_z,
  input  wire logic                       rst_bit,
  output logic      [31:0]                count_q,
  output logic                            rst_evt_q
);
  logic [FILT_W-1:0] flt_cnt_q [3];
  logic              flt_q [3];
  logic [2:0]        raw;
  logic [2:0]        flt;
  logic [2:0]        prev_q;
  logic [2:0]        rise;
  logic [FILT_W-1:0] lim;
  logic              enabled;
  logic              up;
  logic              dn;
  logic              rst_bit_q;
  logic              rst_ev;
  logic [31:0]       eff_max;
  logic [31:0]       count_d;

  // ==========================================================================
  // Noise filter: a level is taken once it has been stable for lim+1 cycles.
  assign raw = {pin_z, pin_b, pin_a};
  assign enabled = (cfg.freq != pcic_pkg::FQ_OFF);
  assign lim = (cfg.freq == pcic_pkg::FQ_100K) ? FILT_W'(pcic_pkg::FILT_100K_CYC)
                                                : FILT_W'(pcic_pkg::FILT_60K_CYC);

  generate
    for (genvar k = 0; k < 3; k++)
    begin : g_flt
      assign flt[k] = flt_q[k];
      always_ff @(posedge clk)
      begin
        if (reset || raw[k] == flt_q[k])
        begin
          flt_cnt_q[k] <= '0;
          flt_q[k] <= reset ? 1'b0 : flt_q[k];
        end
        else if (flt_cnt_q[k] >= lim)
        begin
          flt_cnt_q[k] <= '0;
          flt_q[k] <= raw[k];
        end
        else
          flt_cnt_q[k] <= flt_cnt_q[k] + 1'b1;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    prev_q <= reset ? 3'h0 : flt;
    rst_bit_q <= reset ? 1'b0 : rst_bit;
  end

  assign rise = flt & ~prev_q;

  // ==========================================================================
  // Input decoding.
  always_comb
  begin
    up = 1'b0;
    dn = 1'b0;
    case (cfg.enc)
      pcic_pkg::ENC_QUAD:
        if ((flt[0] ^ prev_q[0]) ^ (flt[1] ^ prev_q[1]))
        begin
          up = flt[0] ^ prev_q[1];
          dn = !(flt[0] ^ prev_q[1]);
        end
      pcic_pkg::ENC_PDIR:
      begin
        up = rise[0] && !flt[1];
        dn = rise[0] && flt[1];
      end
      pcic_pkg::ENC_UPDN:
      begin
        up = rise[0] && !rise[1];
        dn = rise[1] && !rise[0];
      end
      pcic_pkg::ENC_INC:
        up = rise[0];
      default:
        up = 1'b0;
    endcase
  end

  assign eff_max = (ring_max == '0) ? pcic_pkg::FULL_MAX : ring_max;
  assign rst_ev = enabled && (cfg.sw_only ? (rst_bit && !rst_bit_q)
                                          : (rise[2] && rst_bit));

  // ==========================================================================
  // Count value update.
  always_comb
  begin
    count_d = count_q;
    if (!enabled || rst_ev)
      count_d = '0;
    else if (cfg.ring)
    begin
      if (up)
        count_d = (count_q >= eff_max) ? '0 : count_q + 32'h1;
      else if (dn)
        count_d = (count_q == '0) ? eff_max : count_q - 32'h1;
    end
    else if (up && count_q != pcic_pkg::LIN_MAX)
      count_d = count_q + 32'h1;
    else if (dn && count_q != pcic_pkg::LIN_MIN)
      count_d = count_q - 32'h1;
  end

  always_ff @(posedge clk)
  begin
    count_q <= reset ? 32'h0 : count_d;
    rst_evt_q <= reset ? 1'b0 : rst_ev;
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_unused_zero: assert property (!enabled |=> count_q == '0)
    else $error("Unused counter holds a nonzero value.");
  a_ring_wrap: assert property (cfg.ring && up && !rst_ev && enabled
    && count_q == eff_max |=> count_q == '0)
    else $error("Ring counter did not wrap to zero past its maximum.");
  a_ring_zero_max: assert property (enabled && cfg.ring && ring_max == '0 && dn
    && !rst_ev && count_q == '0 |=> count_q == pcic_pkg::FULL_MAX)
    else $error("Zero ring maximum not treated as full range.");
  a_linear_hold: assert property (enabled && !cfg.ring && up && !rst_ev
    && count_q == pcic_pkg::LIN_MAX |=> $stable(count_q))
    else $error("Linear counter wrapped at its upper limit.");
  a_reset_src: assert property (enabled && cfg.sw_only && $rose(rst_bit)
    |=> count_q == '0 && rst_evt_q)
    else $error("Software reset did not clear the counter.");
endmodule
`default_nettype wire

// *** hdl/pcic_top.sv ***
// Operation
// - Each input: plain, fast-capture or interrupt
// - Interrupt on selected edge, rising by default
// - Interrupt event latches selected source value
// - Counter unused or 60/100 kHz filter
// - Counter runs linear or ring mode
// - Ring mode wraps to zero past maximum
// - Ring maximum zero means full range
// - Reset by index and bit, or bit
// - Comparison stops or continues on reset
// - Quadrature, pulse-direction, up-down or increment decoding
// - Mode, maximum, edge load at operation start
// - Other settings load only at power-on
`timescale 1ns/100ps
`default_nettype none
module pcic_top #(
  parameter int FILT_W = 8
) (
  input  wire logic                                 CLK,
  input  wire logic                                 RESET,
  input  wire logic [pcic_pkg::ADDR_W-1:0]          ADDR,
  input  wire logic [pcic_pkg::DATA_W-1:0]          WDATA,
  input  wire logic                                 WE,
  input  wire logic                                 RE,
  output logic      [pcic_pkg::DATA_W-1:0]          RDATA,
  output logic                                      IRQ,
  input  wire logic [pcic_pkg::NUM_IN-1:0]          INT_PIN,
  input  wire logic [pcic_pkg::NUM_CNT-1:0]         CNT_A,
  input  wire logic [pcic_pkg::NUM_CNT-1:0]         CNT_B,
  input  wire logic [pcic_pkg::NUM_CNT-1:0]         CNT_Z,
  input  wire logic [pcic_pkg::NUM_PO-1:0][31:0]    PULSE_POS
);
  localparam int NI = pcic_pkg::NUM_IN;
  localparam int NC = pcic_pkg::NUM_CNT;
  localparam int LW = pcic_pkg::LANE_W;
  localparam int CW = pcic_pkg::CFG_W;

  logic [15:0]                pin_s1_q;
  logic [15:0]                pin_s2_q;
  logic [NI-1:0]              in_lvl;
  logic [NI-1:0]              in_prev_q;
  logic [NI-1:0]              in_ev;
  logic [NI-1:0]              fast_set;
  logic [NI-1:0]              fast_q;
  pcic_pkg::pcic_run_type     run_q;
  logic [31:0]                stage_in_q;
  logic [31:0]                stage_cnt_q;
  logic [31:0]                stage_ring_q [NC];
  pcic_pkg::pcic_in_cfg_type  act_in_q [NI];
  pcic_pkg::pcic_cnt_cfg_type act_cnt_q [NC];
  logic [31:0]                act_ring_q [NC];
  logic [31:0]                latch_q [NI];
  logic [31:0]                cnt_val [NC];
  logic [NC-1:0]              cnt_rst_ev;
  logic [NC-1:0]              rst_bits_q;
  logic [NC-1:0]              cmp_q;
  logic [NC-1:0]              cmp_d;
  logic [pcic_pkg::EV_W-1:0]  irq_stat_q;
  logic [pcic_pkg::EV_W-1:0]  irq_stat_d;
  logic [pcic_pkg::EV_W-1:0]  irq_mask_q;
  logic [31:0]                rdata_q;
  logic [31:0]                rd_d;
  logic                       irq_q;
  logic                       ctrl_wr;
  logic                       por_ld;
  logic                       start_ld;
  logic [3:0]                 page;
  logic [1:0]                 idx;

  assign RDATA = rdata_q;
  assign IRQ = irq_q;
  assign page = ADDR[7:4];
  assign idx = ADDR[3:2];

  // ==========================================================================
  // Pin synchronisers.
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      pin_s1_q <= 16'h0000;
      pin_s2_q <= 16'h0000;
    end
    else
    begin
      pin_s1_q <= {CNT_Z, CNT_B, CNT_A, INT_PIN};
      pin_s2_q <= pin_s1_q;
    end
  end

  assign in_lvl = pin_s2_q[NI-1:0];

  always_ff @(posedge CLK)
  begin
    in_prev_q <= RESET ? '0 : in_lvl;
  end

  // ==========================================================================
  // Power-on and operation-start loading.
  assign ctrl_wr = WE && ADDR == pcic_pkg::OFS_CTRL;
  assign por_ld = ctrl_wr && WDATA[pcic_pkg::CTRL_POWER_ON];
  assign start_ld = ctrl_wr && WDATA[pcic_pkg::CTRL_START] && run_q == pcic_pkg::ST_STOP;

  always_ff @(posedge CLK)
  begin
    if (RESET)
      run_q <= pcic_pkg::ST_STOP;
    else if (start_ld)
      run_q <= pcic_pkg::ST_RUN;
    else if (ctrl_wr && WDATA[pcic_pkg::CTRL_STOP])
      run_q <= pcic_pkg::ST_STOP;
  end

  generate
    for (genvar i = 0; i < NI; i++)
    begin : g_in
      pcic_pkg::pcic_in_cfg_type stg;
      logic hit;
      assign stg = pcic_pkg::pcic_in_cfg_type'(stage_in_q[i*LW +: CW]);

      always_ff @(posedge CLK)
      begin
        if (RESET)
          act_in_q[i] <= pcic_pkg::IN_CFG_RST;
        else
        begin
          if (por_ld)
          begin
            act_in_q[i].func <= stg.func;
            act_in_q[i].latch <= stg.latch;
          end
          if (start_ld)
            act_in_q[i].fall <= stg.fall;
        end
      end

      // Only the function that is active acts on the pin.
      assign hit = act_in_q[i].fall ? (!in_lvl[i] && in_prev_q[i])
                                    : (in_lvl[i] && !in_prev_q[i]);
      assign in_ev[i] = run_q == pcic_pkg::ST_RUN && act_in_q[i].func == pcic_pkg::FN_IRQ
                        && hit;
      assign fast_set[i] = act_in_q[i].func == pcic_pkg::FN_FAST
                           && in_lvl[i] && !in_prev_q[i];

      always_ff @(posedge CLK)
      begin
        if (RESET)
          latch_q[i] <= 32'h0;
        else if (in_ev[i] && act_in_q[i].latch != pcic_pkg::LATCH_NONE)
        begin
          if (act_in_q[i].latch < pcic_pkg::LATCH_CNT0)
            latch_q[i] <= PULSE_POS[2'(act_in_q[i].latch - pcic_pkg::LATCH_PO0)];
          else if (act_in_q[i].latch <= pcic_pkg::LATCH_LAST)
            latch_q[i] <= cnt_val[2'(act_in_q[i].latch - pcic_pkg::LATCH_CNT0)];
        end
      end
    end
  endgenerate

  // A fast-capture pulse stays caught until the pin state is read.
  always_ff @(posedge CLK)
  begin
    if (RESET)
      fast_q <= '0;
    else
      fast_q <= ((RE && ADDR == pcic_pkg::OFS_PIN_STATE) ? '0 : fast_q) | fast_set;
  end

  // ==========================================================================
  // Counters.
  generate
    for (genvar c = 0; c < NC; c++)
    begin : g_cnt
      pcic_pkg::pcic_cnt_cfg_type stg;
      assign stg = pcic_pkg::pcic_cnt_cfg_type'(stage_cnt_q[c*LW +: CW]);

      always_ff @(posedge CLK)
      begin
        if (RESET)
        begin
          act_cnt_q[c] <= pcic_pkg::CNT_CFG_RST;
          act_ring_q[c] <= pcic_pkg::RING_MAX_RST;
        end
        else
        begin
          if (por_ld)
          begin
            act_cnt_q[c].freq <= stg.freq;
            act_cnt_q[c].sw_only <= stg.sw_only;
            act_cnt_q[c].cont <= stg.cont;
            act_cnt_q[c].enc <= stg.enc;
          end
          if (por_ld || start_ld)
          begin
            act_cnt_q[c].ring <= stg.ring;
            act_ring_q[c] <= stage_ring_q[c];
          end
        end
      end

      pcic_counter #(
        .FILT_W (FILT_W)
      ) u_cnt (
        .clk       (CLK),
        .reset     (RESET),
        .cfg       (act_cnt_q[c]),
        .ring_max  (act_ring_q[c]),
        .pin_a     (pin_s2_q[NI+c]),
        .pin_b     (pin_s2_q[NI+NC+c]),
        .pin_z     (pin_s2_q[NI+2*NC+c]),
        .rst_bit   (rst_bits_q[c]),
        .count_q   (cnt_val[c]),
        .rst_evt_q (cnt_rst_ev[c])
      );

      // A counter reset ends comparison unless it is set to continue.
      assign cmp_d[c] = (cnt_rst_ev[c] && !act_cnt_q[c].cont) ? 1'b0
                      : (WE && ADDR == pcic_pkg::OFS_CMP_FLAGS) ? WDATA[c]
                      : cmp_q[c];
    end
  endgenerate

  always_ff @(posedge CLK)
  begin
    cmp_q <= RESET ? '0 : cmp_d;
  end

  // ==========================================================================
  // Register writes.
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      stage_in_q <= pcic_pkg::STAGE_RST;
      stage_cnt_q <= pcic_pkg::STAGE_RST;
      rst_bits_q <= '0;
      irq_mask_q <= '0;
      for (int k = 0; k < NC; k++)
        stage_ring_q[k] <= pcic_pkg::RING_MAX_RST;
    end
    else if (WE)
    begin
      case (ADDR)
        pcic_pkg::OFS_IN_CFG:   stage_in_q <= WDATA;
        pcic_pkg::OFS_CNT_CFG:  stage_cnt_q <= WDATA;
        pcic_pkg::OFS_RST_BITS: rst_bits_q <= WDATA[NC-1:0];
        pcic_pkg::OFS_IRQ_MASK: irq_mask_q <= WDATA[pcic_pkg::EV_W-1:0];
        default:
          if (page == pcic_pkg::PAGE_RING)
            stage_ring_q[idx] <= WDATA;
      endcase
    end
  end

  // ==========================================================================
  // Interrupt status: a read clears, a new event in that cycle still sets.
  assign irq_stat_d = ((RE && ADDR == pcic_pkg::OFS_IRQ_STAT) ? '0 : irq_stat_q)
                      | {cnt_rst_ev, in_ev};

  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      irq_stat_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  // ==========================================================================
  // Register reads.
  always_comb
  begin
    rd_d = 32'h0;
    case (ADDR)
      pcic_pkg::OFS_CTRL:      rd_d[pcic_pkg::CTRL_RUN] = (run_q == pcic_pkg::ST_RUN);
      pcic_pkg::OFS_IN_CFG:    rd_d = stage_in_q;
      pcic_pkg::OFS_CNT_CFG:   rd_d = stage_cnt_q;
      pcic_pkg::OFS_RST_BITS:  rd_d[NC-1:0] = rst_bits_q;
      pcic_pkg::OFS_CMP_FLAGS: rd_d[NC-1:0] = cmp_q;
      pcic_pkg::OFS_IRQ_STAT:  rd_d[pcic_pkg::EV_W-1:0] = irq_stat_q;
      pcic_pkg::OFS_IRQ_MASK:  rd_d[pcic_pkg::EV_W-1:0] = irq_mask_q;
      pcic_pkg::OFS_PIN_STATE: rd_d[2*NI-1:0] = {fast_q, in_lvl};
      default:
        case (page)
          pcic_pkg::PAGE_RING:  rd_d = stage_ring_q[idx];
          pcic_pkg::PAGE_COUNT: rd_d = cnt_val[idx];
          pcic_pkg::PAGE_LATCH: rd_d = latch_q[idx];
          default:              rd_d = 32'h0;
        endcase
    endcase
  end

  always_ff @(posedge CLK)
  begin
    rdata_q <= (RESET || !RE) ? 32'h0 : rd_d;
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_rise0;
    run_q == pcic_pkg::ST_RUN && act_in_q[0].func == pcic_pkg::FN_IRQ && !act_in_q[0].fall
    && in_lvl[0] && !in_prev_q[0];
  endsequence

  sequence s_stat0_irq;
    irq_stat_q[0] ##0 (irq_mask_q[0] ? irq_q : 1'b1);
  endsequence

  a_edge_irq: assert property (s_rise0 |=> s_stat0_irq)
    else $error("Rising edge did not raise the input interrupt.");
  a_func_quiet: assert property (act_in_q[2].func != pcic_pkg::FN_IRQ |-> !in_ev[2])
    else $error("Non-interrupt input produced an interrupt event.");
  a_fast_catch: assert property (fast_set[2] |=> fast_q[2])
    else $error("Fast-capture pulse was not caught.");
  a_latch_cnt: assert property (in_ev[1] && act_in_q[1].latch == pcic_pkg::LATCH_CNT0
    |=> latch_q[1] == $past(cnt_val[0]))
    else $error("Latched value differs from counter value at the event.");
  a_latch_po: assert property (in_ev[0] && act_in_q[0].latch == pcic_pkg::LATCH_PO0
    |=> latch_q[0] == $past(PULSE_POS[0]))
    else $error("Latched value differs from pulse output at the event.");
  a_por_hold: assert property (!por_ld |=> $stable(act_in_q[0].func)
    && $stable(act_cnt_q[0].enc))
    else $error("Power-on setting changed without power-on load.");
  a_edge_hold: assert property (!start_ld && !por_ld |=> $stable(act_in_q[0].fall)
    && $stable(act_ring_q[0]))
    else $error("Start setting changed without operation start.");
  a_cmp_stop: assert property (cnt_rst_ev[2] && !act_cnt_q[2].cont |=> !cmp_q[2])
    else $error("Comparison kept running after counter reset.");
  a_cmp_keep: assert property (cnt_rst_ev[3] && act_cnt_q[3].cont
    && !(WE && ADDR == pcic_pkg::OFS_CMP_FLAGS) |=> cmp_q[3] == $past(cmp_q[3]))
    else $error("Comparison stopped although set to continue.");
  a_rd_clear: assert property (RE && ADDR == pcic_pkg::OFS_IRQ_STAT
    && !(|{cnt_rst_ev, in_ev}) |=> irq_stat_q == '0 && !irq_q)
    else $error("Status read did not clear interrupt state.");
endmodule
`default_nettype wire

// *** bench/pcic_src_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcic_src_model (
  input  wire logic       clk,
  output logic      [3:0] a_o,
  output logic      [3:0] b_o,
  output logic      [3:0] z_o
);
  // ==========================================================================
  // Pulse source: pulse and index lines return low, direction and quadrature levels are held; levels outlast the filter.
  localparam int HOLD = 300;

  initial
  begin
    a_o = '0;
    b_o = '0;
    z_o = '0;
  end

  task automatic pulses(input int c, input int n, input logic dn, input logic on_b);
    @(posedge clk);
    b_o[c] <= dn;
    repeat (HOLD) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      if (on_b)
        b_o[c] <= 1'b1;
      else
        a_o[c] <= 1'b1;
      repeat (HOLD) @(posedge clk);
      if (on_b)
        b_o[c] <= 1'b0;
      else
        a_o[c] <= 1'b0;
      repeat (HOLD) @(posedge clk);
    end
  endtask

  // Quadrature steps with phase A leading, one phase changing per step.
  task automatic quad(input int c, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      if (i % 2 == 0)
        a_o[c] <= ~a_o[c];
      else
        b_o[c] <= ~b_o[c];
      repeat (HOLD) @(posedge clk);
    end
  endtask

  task automatic index_pulse(input int c);
    @(posedge clk);
    z_o[c] <= 1'b1;
    repeat (HOLD) @(posedge clk);
    z_o[c] <= 1'b0;
    repeat (HOLD) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic             clk;
  logic             reset;
  logic [7:0]       addr;
  logic [31:0]      wdata;
  logic             we;
  logic             re;
  logic [31:0]      rdata;
  logic             irq;
  logic [3:0]       int_pin;
  wire  [3:0]       cnt_a;
  wire  [3:0]       cnt_b;
  wire  [3:0]       cnt_z;
  logic [3:0][31:0] pulse_pos;
  logic [31:0]      seed;
  logic [31:0]      cnt_m [4];
  int               num_errors;
  int               n_compared;
  int               cyc;

  pcic_top i_dut (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WE(we),
    .RE(re), .RDATA(rdata), .IRQ(irq), .INT_PIN(int_pin), .CNT_A(cnt_a),
    .CNT_B(cnt_b), .CNT_Z(cnt_z), .PULSE_POS(pulse_pos));
  pcic_src_model i_src (.clk(clk), .a_o(cnt_a), .b_o(cnt_b), .z_o(cnt_z));

  // ==========================================================================
  // Reference model and helpers.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic void step(int c, bit up, bit ring, logic [31:0] mx);
    logic [31:0] m;
    m = (mx == 0) ? 32'hFFFF_FFFF : mx;
    if (ring)
      cnt_m[c] = up ? ((cnt_m[c] >= m) ? '0 : cnt_m[c] + 1) : ((cnt_m[c] == 0) ? m : cnt_m[c] - 1);
    else if (up && cnt_m[c] != 32'h7FFF_FFFF)
      cnt_m[c] = cnt_m[c] + 1;
    else if (!up && cnt_m[c] != 32'h8000_0000)
      cnt_m[c] = cnt_m[c] - 1;
  endfunction

  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    addr <= a;
    re   <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1;
    cmp(n, e, rdata);
  endtask

  task automatic final_report();
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Clock, timeout and main sequence.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      num_errors++;
      final_report();
    end
  end

  initial
  begin
    reset = 1'b1;
    addr = '0;
    wdata = '0;
    we = 1'b0;
    re = 1'b0;
    int_pin = '0;
    seed = 32'h2806;
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      pulse_pos[i] = seed;
      cnt_m[i] = '0;
    end
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_chk(pcic_pkg::OFS_CTRL, '0, "ctrl");
    rd_chk(pcic_pkg::OFS_IN_CFG, '0, "in_cfg");
    rd_chk(pcic_pkg::OFS_CNT_CFG, '0, "cnt_cfg");
    rd_chk(8'h20, '0, "ring_max");
    rd_chk(pcic_pkg::OFS_IRQ_STAT, '0, "status");
    wr(pcic_pkg::OFS_IN_CFG, 32'h0001_2E0A);
    wr(pcic_pkg::OFS_CNT_CFG, 32'h116A_2146);
    wr(8'h20, 32'h3);
    wr(pcic_pkg::OFS_CTRL, 32'h1);
    wr(pcic_pkg::OFS_CTRL, 32'h2);
    wr(pcic_pkg::OFS_IRQ_MASK, 32'h13);
    wr(pcic_pkg::OFS_CMP_FLAGS, 32'hF);
    rd_chk(pcic_pkg::OFS_CTRL, 32'h1, "running");
    i_src.pulses(0, 5, 1'b0, 1'b0);
    repeat (5) step(0, 1'b1, 1'b1, 32'h3);
    rd_chk(8'h30, cnt_m[0], "ring count");
    i_src.pulses(1, 3, 1'b1, 1'b0);
    repeat (3) step(1, 1'b0, 1'b0, '0);
    rd_chk(8'h34, cnt_m[1], "dir count");
    i_src.pulses(2, 2, 1'b0, 1'b0);
    i_src.pulses(2, 1, 1'b0, 1'b1);
    step(2, 1'b1, 1'b0, '0);
    step(2, 1'b1, 1'b0, '0);
    step(2, 1'b0, 1'b0, '0);
    rd_chk(8'h38, cnt_m[2], "updown count");
    wr(pcic_pkg::OFS_RST_BITS, 32'h4);
    wr(pcic_pkg::OFS_RST_BITS, 32'h0);
    rd_chk(8'h38, '0, "sw reset");
    i_src.quad(3, 6);
    repeat (6) step(3, 1'b1, 1'b0, '0);
    rd_chk(8'h3C, cnt_m[3], "quad count");
    wr(pcic_pkg::OFS_RST_BITS, 32'h8);
    i_src.index_pulse(3);
    wr(pcic_pkg::OFS_RST_BITS, 32'h0);
    cnt_m[3] = '0;
    rd_chk(8'h3C, cnt_m[3], "index reset");
    rd_chk(pcic_pkg::OFS_CMP_FLAGS, 32'hB, "compare flags");
    cmp("irq idle", '0, {31'h0, irq});
    @(posedge clk) int_pin <= 4'hB;
    repeat (8) @(posedge clk);
    cmp("irq rise", 32'h1, {31'h0, irq});
    @(posedge clk) int_pin <= 4'hD;
    repeat (8) @(posedge clk);
    int_pin <= 4'h9;
    repeat (8) @(posedge clk);
    rd_chk(pcic_pkg::OFS_IRQ_STAT, 32'hC3, "status");
    repeat (2) @(posedge clk);
    cmp("irq clear", '0, {31'h0, irq});
    rd_chk(8'h40, pulse_pos[0], "latch po");
    rd_chk(8'h44, cnt_m[0], "latch cnt");
    rd_chk(pcic_pkg::OFS_PIN_STATE, 32'h49, "pins");
    rd_chk(8'h7C, '0, "unmapped");
    final_report();
  end
endmodule
`default_nettype wire
